// *** hdl/alc_pkg.sv ***
package alc_pkg;
	// least times round up to whole cycles, never below one
	function automatic int alc_cyc(input int ns, input int clk_ns);
		int c;
		c = (ns + clk_ns - 1) / clk_ns;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int ALC_CLK_NS = 10;
	localparam int ALC_RST_DLY_NS = 30;
	localparam int ALC_SAMP_NS = 100;
	localparam int ALC_SDLY_NS = 50;
	localparam int ALC_RDE_NS = 560;
	localparam int ALC_RESDA_NS = 600;
	localparam int ALC_WAIT_NS = 100;
	localparam int ALC_FCLK_NS = 300;
	localparam int ALC_TP1_NS = 100;
	localparam int ALC_TP2_NS = 100;
	localparam int ALC_THOLD_NS = 125;
	localparam int ALC_RST_DLY_CYC = alc_cyc(ALC_RST_DLY_NS, ALC_CLK_NS);
	localparam int ALC_SAMP_CYC = alc_cyc(ALC_SAMP_NS, ALC_CLK_NS);
	localparam int ALC_SDLY_CYC = alc_cyc(ALC_SDLY_NS, ALC_CLK_NS);
	localparam int ALC_RDE_CYC = alc_cyc(ALC_RDE_NS, ALC_CLK_NS);
	localparam int ALC_RESDA_CYC = alc_cyc(ALC_RESDA_NS, ALC_CLK_NS);
	localparam int ALC_WAIT_CYC = alc_cyc(ALC_WAIT_NS, ALC_CLK_NS);
	localparam int ALC_FCLK_CYC = alc_cyc(ALC_FCLK_NS, ALC_CLK_NS);
	localparam int ALC_TP1_CYC = alc_cyc(ALC_TP1_NS, ALC_CLK_NS);
	localparam int ALC_TP2_CYC = alc_cyc(ALC_TP2_NS, ALC_CLK_NS);
	localparam int ALC_THOLD_CYC = alc_cyc(ALC_THOLD_NS, ALC_CLK_NS);

	// register byte offsets; receive file entries at 0x10 + 4 * line
	localparam logic [4:0] ALC_OFS_CTRL = 5'h00;
	localparam logic [4:0] ALC_OFS_DIV = 5'h04;
	localparam logic [4:0] ALC_OFS_STAT = 5'h08;
	localparam logic [4:0] ALC_OFS_TXD = 5'h0c;
	localparam int ALC_OFS_RXF_BIT = 4;
	// control fields, four bits per line field
	localparam int ALC_CTL_LOOP = 0;
	localparam int ALC_CTL_RXEN = 4;
	localparam int ALC_CTL_BRK = 8;
	localparam int ALC_CTL_HDX = 12;
	localparam int ALC_CTL_SPD17 = 16;
	localparam int ALC_CTL_PEN = 20;
	localparam int ALC_CTL_PODD = 21;
	localparam int ALC_TXD_LINE = 8;
	localparam logic [31:0] ALC_CTRL_RST = 32'h0;
	localparam logic [15:0] ALC_DIV_RST = 16'h00a2;
	// two-bit error code: none, parity, overrun, framing
	localparam logic [1:0] ALC_ERR_NONE = 2'h0;
	localparam logic [1:0] ALC_ERR_PE = 2'h1;
	localparam logic [1:0] ALC_ERR_OVR = 2'h2;
	localparam logic [1:0] ALC_ERR_FE = 2'h3;

	typedef struct packed {logic par_en; logic par_odd;} alc_fmt_t;
	typedef struct packed {logic fe; logic pe; logic ovr;} alc_errl_t;
	typedef struct packed {logic [1:0] err; logic [7:0] data;} alc_rxw_t;
	typedef enum logic [2:0] {
		RS_DLY = 3'h0, RS_SAMP = 3'h1, RS_SDLY = 3'h2, RS_RDE = 3'h3,
		RS_LOAD = 3'h4, RS_RESDA = 3'h5, RS_WAIT = 3'h6
	} alc_rs_t;
	typedef enum logic [1:0] {TS_DLY = 2'h0, TS_P1 = 2'h1, TS_P2 = 2'h2, TS_P3 = 2'h3} alc_ts_t;

	function automatic logic [1:0] alc_hi(input logic [3:0] v);
		return v[3] ? 2'h3 : v[2] ? 2'h2 : v[1] ? 2'h1 : 2'h0;
	endfunction
	function automatic logic [3:0] alc_onehot(input logic [1:0] i);
		return 4'h1 << i;
	endfunction
endpackage

// *** hdl/alc_line_card.sv ***
// Notes on behaviour
// - error lines encode to two bits by priority
// - reading receive entry clears its receiver flag
// - reset, 30 ns, then 100 ns sample pulse
// - no resampling while group select active
// - enable selected receiver, load file after 560 ns
// - 600 ns pulse, then drop enable, set flag
// - wait end clears requests, resumes sampling
// - flag set and data again holds busy
// - loopback feeds receiver from own transmitter
// - disabled receiver input forced to mark
// - break forces transmit line to space
// - half duplex marks receiver while sending
// - transmit file: four eight-bit entries, indexed
// - flag clock hides flag, load shows it
// - transmit scanner three timed pulses, cycles continuously
// - serve highest line, strobe, hold 125 ns
// - request needs flag hidden, done, empty, no stop
// - stop only at speed 17, not looped
// - idle mark, start, data lsb first, parity, stop
// - uart clock sixteen times bit rate
// - start bit rechecked at mid-bit
// - parity mismatch and space stop flag errors
// - one cycle after stop, hold and flag
// - unserviced previous character sets overrun
`timescale 1ns/100ps
module alc_uart (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_srst,
	// format and 16x tick
	input wire logic i_tick,
	input wire alc_pkg::alc_fmt_t i_fmt,
	// transmitter
	input wire logic i_ld,
	input wire logic [7:0] i_tx_data,
	output logic o_tx,
	output logic o_tx_empty,
	output logic o_eoc,
	// receiver
	input wire logic i_rx,
	input wire logic i_clr_da,
	output logic o_da,
	output logic [7:0] o_rx_data,
	output alc_pkg::alc_errl_t o_err
);
	logic [7:0] thr_ff;
	logic thr_full_ff;
	logic busy_ff;
	logic [10:0] sh_ff;
	logic [3:0] nb_ff;
	logic [3:0] tc_ff;
	logic rx_prev_ff;
	logic ract_ff;
	logic xfer_ff;
	logic da_ff;
	logic fe_ff;
	logic rpar_ff;
	logic [3:0] rc_ff;
	logic [3:0] rb_ff;
	logic [7:0] rsh_ff;
	logic [7:0] rhold_ff;
	alc_pkg::alc_errl_t err_ff;

	wire start_w = !busy_ff && thr_full_ff;
	wire par_bit_w = i_fmt.par_en ? (^thr_ff ^ i_fmt.par_odd) : 1'b1;
	wire [3:0] stop_idx_w = i_fmt.par_en ? 4'ha : 4'h9;
	wire mid_w = ract_ff && i_tick && (rc_ff == 4'h7);
	wire rx_pe_w = i_fmt.par_en && ((^rsh_ff ^ rpar_ff) != i_fmt.par_odd);

	// frame is shifted out lsb first; shifter refills with mark
	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
		begin
			thr_ff <= 8'h0;
			thr_full_ff <= 1'b0;
			busy_ff <= 1'b0;
			sh_ff <= 11'h7ff;
			nb_ff <= 4'h0;
			tc_ff <= 4'h0;
		end
		else
		begin
			if (i_ld && !thr_full_ff)
			begin
				thr_ff <= i_tx_data;
				thr_full_ff <= 1'b1;
			end
			if (start_w)
			begin
				thr_full_ff <= 1'b0;
				busy_ff <= 1'b1;
				sh_ff <= {1'b1, par_bit_w, thr_ff, 1'b0};
				nb_ff <= i_fmt.par_en ? 4'hb : 4'ha;
				tc_ff <= 4'h0;
			end
			else if (busy_ff && i_tick)
			begin
				tc_ff <= tc_ff + 4'h1;
				if (tc_ff == 4'hf)
				begin
					sh_ff <= {1'b1, sh_ff[10:1]};
					nb_ff <= nb_ff - 4'h1;
					busy_ff <= (nb_ff != 4'h1);
				end
			end
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
		begin
			rx_prev_ff <= 1'b1;
			ract_ff <= 1'b0;
			xfer_ff <= 1'b0;
			da_ff <= 1'b0;
			fe_ff <= 1'b0;
			rpar_ff <= 1'b0;
			rc_ff <= 4'h0;
			rb_ff <= 4'h0;
			rsh_ff <= 8'h0;
			rhold_ff <= 8'h0;
			err_ff <= '0;
		end
		else
		begin
			xfer_ff <= 1'b0;
			if (i_tick)
				rx_prev_ff <= i_rx;
			if (!ract_ff && i_tick && rx_prev_ff && !i_rx)
			begin
				ract_ff <= 1'b1;
				rc_ff <= 4'h0;
				rb_ff <= 4'h0;
			end
			else if (ract_ff && i_tick)
				rc_ff <= rc_ff + 4'h1;
			if (mid_w)
			begin
				rb_ff <= rb_ff + 4'h1;
				if (rb_ff == 4'h0 && i_rx)
					ract_ff <= 1'b0;
				else if (rb_ff == stop_idx_w)
				begin
					fe_ff <= !i_rx;
					xfer_ff <= 1'b1;
					ract_ff <= 1'b0;
				end
				else if (rb_ff == 4'h9)
					rpar_ff <= i_rx;
				else if (rb_ff != 4'h0)
					rsh_ff <= {i_rx, rsh_ff[7:1]};
			end
			// set wins over a clear in the same cycle
			if (xfer_ff)
			begin
				rhold_ff <= rsh_ff;
				err_ff.fe <= fe_ff;
				err_ff.pe <= rx_pe_w;
				err_ff.ovr <= da_ff;
				da_ff <= 1'b1;
			end
			else if (i_clr_da)
				da_ff <= 1'b0;
		end
	end

	assign o_tx = sh_ff[0];
	assign o_tx_empty = !thr_full_ff;
	assign o_eoc = !busy_ff;
	assign o_da = da_ff;
	assign o_rx_data = rhold_ff;
	assign o_err = err_ff;
endmodule

module alc_line_card #(
	parameter logic [15:0] DIV_RST = alc_pkg::ALC_DIV_RST
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_srst,
	// avalon-mm slave
	input wire logic [4:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// serial lines
	input wire logic [3:0] i_rx_serial,
	input wire logic [3:0] i_data_set_busy,
	output logic [3:0] o_tx_serial,
	output logic [3:0] o_busy
);
	logic [7:0] pin_s1_ff;
	logic [7:0] pin_s2_ff;
	logic [31:0] ctrl_ff;
	logic [15:0] div_ff;
	logic [15:0] bcnt_ff;
	logic tick_ff;
	logic wait_ff;
	logic [31:0] rdata_ff;
	logic [3:0] tx_ff;
	logic [3:0] busy_ff;
	logic [3:0] rx_flag_ff;
	logic [3:0] rx_req_ff;
	logic [3:0] tx_req_ff;
	logic [3:0] tx_ind_ff;
	logic rde_ff;
	logic [6:0] cnt_ff;
	logic [6:0] nxt_cnt;
	logic [6:0] tcnt_ff;
	logic [6:0] nxt_tcnt;
	logic fact_ff;
	logic [6:0] fcnt_ff;
	logic [1:0] fline_ff;
	alc_pkg::alc_rs_t rs_ff;
	alc_pkg::alc_rs_t nxt_rs;
	alc_pkg::alc_ts_t ts_ff;
	alc_pkg::alc_ts_t nxt_ts;
	alc_pkg::alc_rxw_t rx_file_ff [4];
	logic [7:0] tx_file_ff [4];
	logic [7:0] rxd_w [4];
	alc_pkg::alc_errl_t errl_w [4];
	logic [3:0] uart_tx_w;
	logic [3:0] tx_empty_w;
	logic [3:0] eoc_w;
	logic [3:0] da_w;
	logic [3:0] rx_in_w;
	alc_pkg::alc_fmt_t fmt_w;

	// control fields
	wire [3:0] loop_w = ctrl_ff[alc_pkg::ALC_CTL_LOOP +: 4];
	wire [3:0] rxen_w = ctrl_ff[alc_pkg::ALC_CTL_RXEN +: 4];
	wire [3:0] brk_w = ctrl_ff[alc_pkg::ALC_CTL_BRK +: 4];
	wire [3:0] hdx_w = ctrl_ff[alc_pkg::ALC_CTL_HDX +: 4];
	wire [3:0] spd17_w = ctrl_ff[alc_pkg::ALC_CTL_SPD17 +: 4];
	assign fmt_w = {ctrl_ff[alc_pkg::ALC_CTL_PEN], ctrl_ff[alc_pkg::ALC_CTL_PODD]};

	// bus decode; one wait cycle, then the access edge
	wire acc_w = (i_avs_read || i_avs_write) && !wait_ff;
	wire acc_rd_w = acc_w && i_avs_read;
	wire acc_wr_w = acc_w && i_avs_write;
	wire is_rxf_w = i_avs_address[alc_pkg::ALC_OFS_RXF_BIT];
	wire [1:0] rxf_idx_w = i_avs_address[3:2];
	wire wr_ctrl_w = acc_wr_w && (i_avs_address == alc_pkg::ALC_OFS_CTRL);
	wire wr_div_w = acc_wr_w && (i_avs_address == alc_pkg::ALC_OFS_DIV);
	wire wr_txd_w = acc_wr_w && (i_avs_address == alc_pkg::ALC_OFS_TXD);
	wire [1:0] txd_line_w = i_avs_writedata[alc_pkg::ALC_TXD_LINE +: 2];
	wire [3:0] rx_clr_w = (acc_rd_w && is_rxf_w) ? alc_pkg::alc_onehot(rxf_idx_w) : 4'h0;
	wire [31:0] stat_w = {16'h0, da_w, busy_ff, ~tx_ind_ff, rx_flag_ff};
	wire [31:0] rd_mux_w = is_rxf_w ? {22'h0, rx_file_ff[rxf_idx_w]} :
		(i_avs_address == alc_pkg::ALC_OFS_CTRL) ? ctrl_ff :
		(i_avs_address == alc_pkg::ALC_OFS_DIV) ? {16'h0, div_ff} :
		(i_avs_address == alc_pkg::ALC_OFS_STAT) ? stat_w : 32'h0;

	// receive service decode
	wire rx_grp_w = |rx_req_ff;
	wire [1:0] rx_sel_w = alc_pkg::alc_hi(rx_req_ff);
	wire cnt_done_w = (cnt_ff == 7'h0);
	wire rx_cap_w = (rs_ff == alc_pkg::RS_SAMP) && cnt_done_w;
	wire rx_load_w = (rs_ff == alc_pkg::RS_LOAD);
	wire rx_end_w = (rs_ff == alc_pkg::RS_RESDA) && cnt_done_w;
	wire rx_wait_end_w = (rs_ff == alc_pkg::RS_WAIT) && cnt_done_w;
	wire [3:0] rx_set_w = rx_end_w ? alc_pkg::alc_onehot(rx_sel_w) : 4'h0;
	wire [3:0] nxt_rx_flag = (rx_flag_ff & ~rx_clr_w) | rx_set_w;
	wire alc_pkg::alc_errl_t sel_err_w = errl_w[rx_sel_w];
	wire [1:0] err_enc_w = sel_err_w.ovr ? alc_pkg::ALC_ERR_OVR :
		sel_err_w.fe ? alc_pkg::ALC_ERR_FE :
		sel_err_w.pe ? alc_pkg::ALC_ERR_PE : alc_pkg::ALC_ERR_NONE;
	// character bus only carries data while the receiver output is enabled
	wire [7:0] rx_bus_w = rde_ff ? rxd_w[rx_sel_w] : 8'h0;

	// transmit service decode
	wire [3:0] ext_stop_w = spd17_w & ~loop_w & pin_s2_ff[7:4];
	wire [3:0] tx_req_w = tx_ind_ff & eoc_w & tx_empty_w & ~ext_stop_w;
	wire tx_grp_w = |tx_req_ff;
	wire [1:0] tx_sel_w = alc_pkg::alc_hi(tx_req_ff);
	wire tcnt_done_w = (tcnt_ff == 7'h0);
	wire thr_go_w = (ts_ff == alc_pkg::TS_P2) && tx_grp_w &&
		(tcnt_ff == 7'(alc_pkg::ALC_TP2_CYC - 1));
	wire [3:0] thr_ld_w = thr_go_w ? alc_pkg::alc_onehot(tx_sel_w) : 4'h0;
	wire [3:0] fset_w = (fact_ff && fcnt_ff == 7'h0) ? alc_pkg::alc_onehot(fline_ff) : 4'h0;

	// line routing
	assign rx_in_w = (loop_w & tx_ff) | (~loop_w & pin_s2_ff[3:0])
		| ~rxen_w
		| (hdx_w & ~eoc_w);

	for (genvar g = 0; g < 4; g++)
	begin : g_line
		alc_uart u_uart (
			.i_sys_clk(i_sys_clk),
			.i_srst(i_srst),
			.i_tick(tick_ff),
			.i_fmt(fmt_w),
			.i_ld(thr_ld_w[g]),
			.i_tx_data(tx_file_ff[tx_sel_w]),
			.o_tx(uart_tx_w[g]),
			.o_tx_empty(tx_empty_w[g]),
			.o_eoc(eoc_w[g]),
			.i_rx(rx_in_w[g]),
			.i_clr_da(rx_set_w[g]),
			.o_da(da_w[g]),
			.o_rx_data(rxd_w[g]),
			.o_err(errl_w[g])
		);
	end

	always_comb
	begin
		nxt_rs = rs_ff;
		nxt_cnt = cnt_done_w ? cnt_ff : cnt_ff - 7'h1;
		unique case (rs_ff)
			alc_pkg::RS_DLY:
				if (cnt_done_w)
				begin
					nxt_rs = alc_pkg::RS_SAMP;
					nxt_cnt = 7'(alc_pkg::ALC_SAMP_CYC - 1);
				end
			alc_pkg::RS_SAMP:
				if (cnt_done_w)
				begin
					nxt_rs = alc_pkg::RS_SDLY;
					nxt_cnt = 7'(alc_pkg::ALC_SDLY_CYC - 1);
				end
			alc_pkg::RS_SDLY:
				if (rx_grp_w)
				begin
					nxt_rs = alc_pkg::RS_RDE;
					nxt_cnt = 7'(alc_pkg::ALC_RDE_CYC - 1);
				end
				else if (cnt_done_w)
				begin
					nxt_rs = alc_pkg::RS_SAMP;
					nxt_cnt = 7'(alc_pkg::ALC_SAMP_CYC - 1);
				end
			alc_pkg::RS_RDE:
				if (cnt_done_w)
					nxt_rs = alc_pkg::RS_LOAD;
			alc_pkg::RS_LOAD:
			begin
				nxt_rs = alc_pkg::RS_RESDA;
				nxt_cnt = 7'(alc_pkg::ALC_RESDA_CYC - 1);
			end
			alc_pkg::RS_RESDA:
				if (cnt_done_w)
				begin
					nxt_rs = alc_pkg::RS_WAIT;
					nxt_cnt = 7'(alc_pkg::ALC_WAIT_CYC - 1);
				end
			alc_pkg::RS_WAIT:
				if (cnt_done_w)
				begin
					nxt_rs = alc_pkg::RS_SAMP;
					nxt_cnt = 7'(alc_pkg::ALC_SAMP_CYC - 1);
				end
			default:
				nxt_rs = alc_pkg::RS_DLY;
		endcase
	end

	// no request still cycles the pulses and resamples
	always_comb
	begin
		nxt_ts = ts_ff;
		nxt_tcnt = tcnt_done_w ? tcnt_ff : tcnt_ff - 7'h1;
		unique case (ts_ff)
			alc_pkg::TS_DLY, alc_pkg::TS_P3:
				if (tcnt_done_w)
				begin
					nxt_ts = alc_pkg::TS_P1;
					nxt_tcnt = 7'(alc_pkg::ALC_TP1_CYC - 1);
				end
			alc_pkg::TS_P1:
				if (tcnt_done_w)
				begin
					nxt_ts = alc_pkg::TS_P2;
					nxt_tcnt = 7'(alc_pkg::ALC_TP2_CYC - 1);
				end
			alc_pkg::TS_P2:
				if (tcnt_done_w)
				begin
					nxt_ts = alc_pkg::TS_P3;
					nxt_tcnt = 7'(alc_pkg::ALC_THOLD_CYC - 1);
				end
		endcase
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
		begin
			pin_s1_ff <= 8'h0f;
			pin_s2_ff <= 8'h0f;
			wait_ff <= 1'b1;
			rdata_ff <= 32'h0;
			ctrl_ff <= alc_pkg::ALC_CTRL_RST;
			div_ff <= DIV_RST;
			bcnt_ff <= 16'h0;
			tick_ff <= 1'b0;
			tx_ff <= 4'hf;
		end
		else
		begin
			pin_s1_ff <= {i_data_set_busy, i_rx_serial};
			pin_s2_ff <= pin_s1_ff;
			wait_ff <= !((i_avs_read || i_avs_write) && wait_ff);
			if (wait_ff)
				rdata_ff <= rd_mux_w;
			if (wr_ctrl_w)
				ctrl_ff <= i_avs_writedata;
			if (wr_div_w)
				div_ff <= i_avs_writedata[15:0];
			tick_ff <= (bcnt_ff >= div_ff);
			bcnt_ff <= (bcnt_ff >= div_ff) ? 16'h0 : bcnt_ff + 16'h1;
			tx_ff <= uart_tx_w & ~brk_w;
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
		begin
			rs_ff <= alc_pkg::RS_DLY;
			cnt_ff <= 7'(alc_pkg::ALC_RST_DLY_CYC - 1);
			ts_ff <= alc_pkg::TS_DLY;
			tcnt_ff <= 7'(alc_pkg::ALC_RST_DLY_CYC - 1);
			rx_req_ff <= 4'h0;
			tx_req_ff <= 4'h0;
			rde_ff <= 1'b0;
			rx_flag_ff <= 4'h0;
			busy_ff <= 4'h0;
		end
		else
		begin
			rs_ff <= nxt_rs;
			cnt_ff <= nxt_cnt;
			ts_ff <= nxt_ts;
			tcnt_ff <= nxt_tcnt;
			if (rx_wait_end_w)
				rx_req_ff <= 4'h0;
			else if (rx_cap_w)
				rx_req_ff <= da_w;
			if (ts_ff == alc_pkg::TS_P3 && tcnt_done_w)
				tx_req_ff <= 4'h0;
			else if (ts_ff == alc_pkg::TS_P1 && tcnt_done_w)
				tx_req_ff <= tx_req_w;
			rde_ff <= (rde_ff || (rs_ff == alc_pkg::RS_SDLY && rx_grp_w)) && !rx_end_w;
			rx_flag_ff <= nxt_rx_flag;
			busy_ff <= (busy_ff | (rx_flag_ff & da_w)) & nxt_rx_flag;
		end
	end

	// transmit flag clock: file written at once, flag hidden when the clock ends
	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
		begin
			fact_ff <= 1'b0;
			fcnt_ff <= 7'h0;
			fline_ff <= 2'h0;
			tx_ind_ff <= 4'h0;
		end
		else
		begin
			if (wr_txd_w)
			begin
				fact_ff <= 1'b1;
				fcnt_ff <= 7'(alc_pkg::ALC_FCLK_CYC - 1);
				fline_ff <= txd_line_w;
			end
			else if (fact_ff)
			begin
				fact_ff <= !(fcnt_ff == 7'h0);
				fcnt_ff <= fcnt_ff - 7'h1;
			end
			tx_ind_ff <= (tx_ind_ff & ~thr_ld_w) | fset_w;
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (wr_txd_w)
			tx_file_ff[txd_line_w] <= i_avs_writedata[7:0];
		if (rx_load_w)
			rx_file_ff[rx_sel_w] <= {err_enc_w, rx_bus_w};
	end

	assign o_avs_readdata = rdata_ff;
	assign o_avs_waitrequest = wait_ff;
	assign o_tx_serial = tx_ff;
	assign o_busy = busy_ff;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_srst);
	sequence s_rst_dly;
		rs_ff == alc_pkg::RS_DLY [*3];
	endsequence
	sequence s_samp;
		rs_ff == alc_pkg::RS_SAMP [*8];
	endsequence

	err_code_a: assert property (rx_load_w && sel_err_w.ovr |=>
		rx_file_ff[$past(rx_sel_w)].err == alc_pkg::ALC_ERR_OVR) else $error("overrun code");
	rx_clear_a: assert property (rx_clr_w[0] && !rx_set_w[0] |=> !rx_flag_ff[0])
		else $error("flag not cleared by read");
	rs_dly_a: assert property ($fell(i_srst) |-> s_rst_dly ##1 s_samp)
		else $error("reset sample timing");
	grp_hold_a: assert property (rx_grp_w |-> rs_ff != alc_pkg::RS_SAMP)
		else $error("sampling during group select");
	rde_load_a: assert property ($rose(rde_ff) |-> ##56 rx_load_w)
		else $error("file load timing");
	resda_end_a: assert property (rx_load_w |-> ##61 !rde_ff && $past(rde_ff))
		else $error("enable drop timing");
	wait_clr_a: assert property (rx_wait_end_w |=> rx_req_ff == 4'h0 &&
		rs_ff == alc_pkg::RS_SAMP) else $error("wait end");
	busy_mark_a: assert property (rx_flag_ff[0] && da_w[0] && !rx_clr_w[0] |=> o_busy[0])
		else $error("busy not raised");
	brk_space_a: assert property (brk_w[1] |=> !o_tx_serial[1])
		else $error("break not spacing");
	tx_cycle_a: assert property (ts_ff == alc_pkg::TS_P3 && tcnt_done_w |=>
		ts_ff == alc_pkg::TS_P1 && tx_req_ff == 4'h0) else $error("scan cycle");
	tx_hold_a: assert property (thr_go_w |=> !thr_go_w [*8])
		else $error("strobe hold");
endmodule

// *** bench/alc_term_model.sv ***
`timescale 1ns/100ps
module alc_term_model #(
	parameter int BIT_CYC = 64
) (
	// clock
	input wire logic i_sys_clk,
	// serial lines seen from the terminal side
	input wire logic [3:0] i_line_tx,
	output logic [3:0] o_line_rx
);
	logic [7:0] rx_byte [4];
	int rx_cnt [4];
	// bit time of the frames sent; the bench shortens it for back-to-back traffic
	int bit_cyc = BIT_CYC;

	initial
	begin
		o_line_rx = 4'hf;
		rx_cnt = '{0, 0, 0, 0};
	end

	// twelve bit times always; without parity the last two are plain idle mark
	task automatic send(input int ln, input logic [7:0] d, input logic par, input logic bad_par,
		input logic bad_stop);
		logic [10:0] f;
		f = par ? {~bad_stop, ^d ^ bad_par, d, 1'b0} : {1'b1, ~bad_stop, d, 1'b0};
		for (int i = 0; i < 11; i++)
		begin
			o_line_rx[ln] <= f[i];
			repeat (bit_cyc) @(posedge i_sys_clk);
		end
		o_line_rx[ln] <= 1'b1;
		repeat (bit_cyc) @(posedge i_sys_clk);
	endtask

	for (genvar g = 0; g < 4; g++)
	begin : g_rx
		initial
		begin
			logic [7:0] b;
			forever
			begin
				@(negedge i_line_tx[g]);
				repeat (BIT_CYC / 2) @(posedge i_sys_clk);
				// a start that has gone back to mark at mid-bit is noise
				if (i_line_tx[g] === 1'b0)
				begin
					for (int i = 0; i < 8; i++)
					begin
						repeat (BIT_CYC) @(posedge i_sys_clk);
						b[i] = i_line_tx[g];
					end
					rx_byte[g] = b;
					rx_cnt[g]++;
				end
			end
		end
	end
endmodule

// *** bench/tb.sv ***
`timescale 1ns/100ps
module tb;
	localparam logic [15:0] DIV = 16'h0003;
	localparam int BIT_CYC = 16 * (DIV + 1);
	localparam logic [4:0] A_CTL = alc_pkg::ALC_OFS_CTRL;
	localparam logic [4:0] A_STAT = alc_pkg::ALC_OFS_STAT;
	localparam logic [4:0] A_TXD = alc_pkg::ALC_OFS_TXD;
	logic clk, srst, av_rd, av_wr, av_wait;
	logic [4:0] av_addr;
	logic [31:0] av_wd, av_rdata, rd;
	logic [3:0] rx_ser, set_busy, tx_ser, busy;
	logic [1:0] t_err [3];
	int error_cnt, compares, c0;

	alc_line_card #(.DIV_RST(DIV)) alc_line_card_inst (.i_sys_clk(clk), .i_srst(srst),
		.i_avs_address(av_addr), .i_avs_read(av_rd), .i_avs_write(av_wr),
		.i_avs_writedata(av_wd), .o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait),
		.i_rx_serial(rx_ser), .i_data_set_busy(set_busy), .o_tx_serial(tx_ser), .o_busy(busy));
	alc_term_model #(.BIT_CYC(BIT_CYC)) alc_term_model_inst (.i_sys_clk(clk),
		.i_line_tx(tx_ser), .o_line_rx(rx_ser));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// entered just after an edge; one idle edge after release keeps strobes apart
	task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		av_addr <= a;
		av_wd <= d;
		av_wr <= wr;
		av_rd <= !wr;
		do
		begin
			@(posedge clk);
			n++;
		end while (av_wait !== 1'b0 && n < 50);
		rd = av_rdata;
		av_wr <= 1'b0;
		av_rd <= 1'b0;
		@(posedge clk);
		if (n >= 50)
			chk(32'h1, 32'h0);
	endtask

	task rd_chk(input logic [4:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	task wait_flag(input int ln, input logic v);
		int n;
		n = 0;
		do
		begin
			bus(1'b0, A_STAT, 32'h0);
			n++;
		end while (rd[ln] !== v && n < 400);
		chk({31'h0, rd[ln]}, {31'h0, v});
	endtask

	task wait_busy(input int ln, input logic v);
		int n;
		for (n = 0; n < 500 && busy[ln] !== v; n++)
			@(posedge clk);
		chk({31'h0, busy[ln]}, {31'h0, v});
	endtask

	task wait_tx(input int ln, input int prev, input logic [7:0] exp);
		int n;
		for (n = 0; n < 3000 && alc_term_model_inst.rx_cnt[ln] == prev; n++)
			@(posedge clk);
		chk({24'h0, alc_term_model_inst.rx_byte[ln]}, {24'h0, exp});
	endtask

	task end_of_test;
		$display("comparisons %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// whole run is near 12k cycles
	initial
	begin
		repeat (80000) @(posedge clk);
		error_cnt++;
		end_of_test;
	end

	initial
	begin
		srst = 1'b1;
		av_addr = 5'h00;
		av_rd = 1'b0;
		av_wr = 1'b0;
		av_wd = 32'h0;
		set_busy = 4'h0;
		t_err = '{alc_pkg::ALC_ERR_PE, alc_pkg::ALC_ERR_NONE, alc_pkg::ALC_ERR_FE};
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		chk({28'h0, tx_ser}, 32'hf);
		rd_chk(A_CTL, alc_pkg::ALC_CTRL_RST);
		rd_chk(alc_pkg::ALC_OFS_DIV, {16'h0, DIV});
		rd_chk(A_STAT, 32'hf0);
		rd_chk(A_TXD, 32'h0);
		alc_term_model_inst.send(2, 8'h5a, 1'b0, 1'b0, 1'b0);
		repeat (300) @(posedge clk);
		rd_chk(A_STAT, 32'hf0);
		bus(1'b1, A_CTL, 32'hf0);
		rd_chk(A_CTL, 32'hf0);
		alc_term_model_inst.send(1, 8'h3c, 1'b0, 1'b0, 1'b0);
		wait_flag(1, 1'b1);
		rd_chk(5'h14, {22'h0, alc_pkg::ALC_ERR_NONE, 8'h3c});
		rd_chk(A_STAT, 32'hf0);
		// even parity on: bad parity, clean, bad stop on lines 0, 1, 3
		bus(1'b1, A_CTL, 32'h001000f0);
		for (int i = 0; i < 3; i++)
		begin
			alc_term_model_inst.send(i + i / 2, 8'h81 + i, 1'b1, i == 0, i == 2);
			wait_flag(i + i / 2, 1'b1);
			rd_chk(5'h10 + 4 * (i + i / 2), {22'h0, t_err[i], 8'h81 + 8'(i)});
		end
		alc_term_model_inst.send(1, 8'h11, 1'b1, 1'b0, 1'b0);
		wait_flag(1, 1'b1);
		alc_term_model_inst.send(1, 8'h22, 1'b1, 1'b0, 1'b0);
		wait_busy(1, 1'b1);
		bus(1'b0, 5'h14, 32'h0);
		wait_busy(1, 1'b0);
		wait_flag(1, 1'b1);
		rd_chk(5'h14, {22'h0, alc_pkg::ALC_ERR_NONE, 8'h22});
		// fast frames on three lines: line 0 waits behind 3 and 2 and overruns
		bus(1'b1, alc_pkg::ALC_OFS_DIV, 32'h0);
		alc_term_model_inst.bit_cyc = 16;
		fork
			alc_term_model_inst.send(3, 8'h44, 1'b1, 1'b0, 1'b0);
			alc_term_model_inst.send(2, 8'h45, 1'b1, 1'b0, 1'b0);
			begin
				alc_term_model_inst.send(0, 8'h55, 1'b1, 1'b0, 1'b0);
				alc_term_model_inst.send(0, 8'h66, 1'b1, 1'b0, 1'b0);
			end
		join
		wait_flag(0, 1'b1);
		rd_chk(5'h10, {22'h0, alc_pkg::ALC_ERR_OVR, 8'h66});
		rd_chk(5'h1c, {22'h0, alc_pkg::ALC_ERR_NONE, 8'h44});
		rd_chk(5'h18, {22'h0, alc_pkg::ALC_ERR_NONE, 8'h45});
		alc_term_model_inst.bit_cyc = BIT_CYC;
		bus(1'b1, alc_pkg::ALC_OFS_DIV, {16'h0, DIV});
		// transmit: stop input ignored unless speed 17 chosen
		bus(1'b1, A_CTL, 32'hf0);
		set_busy <= 4'h4;
		c0 = alc_term_model_inst.rx_cnt[2];
		bus(1'b1, A_TXD, 32'h2a5);
		wait_tx(2, c0, 8'ha5);
		rd_chk(A_STAT, 32'hf0);
		set_busy <= 4'h2;
		bus(1'b1, A_CTL, 32'h000200f0);
		c0 = alc_term_model_inst.rx_cnt[1];
		bus(1'b1, A_TXD, 32'h1c3);
		repeat (BIT_CYC * 14) @(posedge clk);
		chk(alc_term_model_inst.rx_cnt[1], c0);
		rd_chk(A_STAT, 32'hd0);
		set_busy <= 4'h0;
		wait_tx(1, c0, 8'hc3);
		c0 = alc_term_model_inst.rx_cnt[3];
		bus(1'b1, A_TXD, 32'h017);
		bus(1'b1, A_TXD, 32'h3e8);
		wait_tx(3, c0, 8'he8);
		repeat (BIT_CYC * 12) @(posedge clk);
		rd_chk(A_STAT, 32'hf0);
		bus(1'b1, A_CTL, 32'hf1);
		bus(1'b1, A_TXD, 32'h069);
		wait_flag(0, 1'b1);
		rd_chk(5'h10, {22'h0, alc_pkg::ALC_ERR_NONE, 8'h69});
		bus(1'b1, A_CTL, 32'h10f1);
		bus(1'b1, A_TXD, 32'h033);
		repeat (BIT_CYC * 14) @(posedge clk);
		rd_chk(A_STAT, 32'hf0);
		bus(1'b1, A_CTL, 32'h08f0);
		repeat (5) @(posedge clk);
		chk({31'h0, tx_ser[3]}, 32'h0);
		end_of_test;
	end
endmodule
